// >>> rtl/bcm_map.vh
`ifndef BCM_MAP_VH
`define BCM_MAP_VH
// opcode second bytes (first byte is the extended-page prefix)
`define BCM_PREFIX          8'hED
`define BCM_OP_MUL_ADD      8'hC0
`define BCM_OP_MUL_SUB      8'hC8
`define BCM_OP_DEC_FIX_DST  8'h98
`define BCM_OP_INC_FIX_DST  8'h90
`define BCM_OP_DEC_SRC_PFX  8'hF8
`define BCM_OP_INC_SRC_PFX  8'hD0
`define BCM_OP_FIX_SRC_DEC  8'h18
`define BCM_OP_FIX_SRC_INC  8'h10
`define BCM_OP_LEG_DEC      8'hB8
`define BCM_OP_LEG_INC      8'hB0
// address step encodings
`define BCM_STEP_NONE       2'b00
`define BCM_STEP_INC        2'b01
`define BCM_STEP_DEC        2'b10
// states
`define BCM_ST_IDLE         3'h0
`define BCM_ST_RD_A         3'h1
`define BCM_ST_RD_B         3'h2
`define BCM_ST_CALC         3'h3
`define BCM_ST_WR           3'h4
`define BCM_ST_DONE         3'h5
`define BCM_ONE16           16'h0001
`define BCM_ZERO16          16'h0000
`endif

// >>> rtl/bcm_skid.v
`timescale 1ns/10ps
`default_nettype none
// ************************************************************
// two-entry buffer for the write stream
// ************************************************************
module bcm_skid #(
    parameter W = 26
) (
    input  wire         clk,
    input  wire         rst,
    input  wire         in_valid,
    output wire         in_ready,
    input  wire [W-1:0] in_data,
    output wire         out_valid,
    input  wire         out_ready,
    output wire [W-1:0] out_data
);
    reg [W-1:0] m0_r;
    reg [W-1:0] m1_r;
    reg [1:0]   cnt_r;
    wire push = in_valid && (cnt_r != 2'h2);
    wire pop  = out_ready && (cnt_r != 2'h0);
    assign in_ready  = (cnt_r != 2'h2);
    assign out_valid = (cnt_r != 2'h0);
    assign out_data  = m0_r;
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            cnt_r <= 2'h0;
            m0_r  <= {W{1'b0}};
            m1_r  <= {W{1'b0}};
        end else begin
            // head shifts on pop; new word lands in first free slot
            if (pop) begin
                m0_r <= (cnt_r == 2'h2) ? m1_r : in_data;
                if (cnt_r == 2'h2 && push)
                    m1_r <= in_data;
            end else if (push) begin
                if (cnt_r == 2'h0)
                    m0_r <= in_data;
                else
                    m1_r <= in_data;
            end
            cnt_r <= cnt_r + {1'b0, push} - {1'b0, pop};
        end
    end
endmodule // bcm_skid
`default_nettype wire

// >>> rtl/bcm_exec.v
`timescale 1ns/10ps
`default_nettype none
`include "bcm_map.vh"
// Function
// - ten two-byte repeating opcodes decoded
// - multiply-add step, carry into alt pair
// - multiply-subtract step, borrow through carry
// - multiply: bump pointers, count down, repeat
// - legacy copies step both, prefix on destination
// - decrement source, fixed destination, prefix destination
// - increment source, fixed destination, prefix destination
// - both step, prefix applies to source
// - fixed source, stepping destination, prefix source
module bcm_exec (
    input  wire        core_clk,
    input  wire        sys_rst,
    input  wire        op_valid,
    input  wire [7:0]  op_prefix,
    input  wire [7:0]  op_code,
    input  wire        io_pfx_int,
    input  wire        io_pfx_ext,
    input  wire [15:0] counter_pair_in,
    input  wire [15:0] second_pair_in,
    input  wire [15:0] alt_second_pair_in,
    input  wire [15:0] third_pair_in,
    input  wire [15:0] first_index_in,
    input  wire [15:0] second_index_in,
    input  wire        carry_flag_in,
    output reg         op_accept,
    output reg         busy,
    output reg         done,
    output reg  [15:0] counter_pair,
    output reg  [15:0] second_pair,
    output reg  [15:0] alt_second_pair,
    output reg  [15:0] third_pair,
    output reg  [15:0] first_index,
    output reg  [15:0] second_index,
    output reg         carry_flag,
    output reg         overflow_flag,
    output reg         rd_req,
    output reg  [15:0] rd_addr,
    output reg         rd_io_int,
    output reg         rd_io_ext,
    input  wire        rd_ack,
    input  wire [7:0]  rd_data,
    output reg         wr_valid,
    input  wire        wr_ready,
    output reg  [15:0] wr_addr,
    output reg  [7:0]  wr_data,
    output reg         wr_io_int,
    output reg         wr_io_ext
);
    // ************************************************************
    // decode
    // ************************************************************
    reg        dec_hit;
    reg        dec_mul;
    reg        dec_sub;
    reg [1:0]  dec_src;
    reg [1:0]  dec_dst;
    reg        dec_pfx_src;
    always @* begin
        dec_hit     = (op_prefix == `BCM_PREFIX);
        dec_mul     = 1'b0;
        dec_sub     = 1'b0;
        dec_src     = `BCM_STEP_NONE;
        dec_dst     = `BCM_STEP_NONE;
        dec_pfx_src = 1'b0;
        case (op_code)
            `BCM_OP_MUL_ADD: dec_mul = 1'b1;
            `BCM_OP_MUL_SUB: begin
                dec_mul = 1'b1;
                dec_sub = 1'b1;
            end
            `BCM_OP_LEG_DEC: begin
                dec_src = `BCM_STEP_DEC;
                dec_dst = `BCM_STEP_DEC;
            end
            `BCM_OP_LEG_INC: begin
                dec_src = `BCM_STEP_INC;
                dec_dst = `BCM_STEP_INC;
            end
            `BCM_OP_DEC_FIX_DST: dec_src = `BCM_STEP_DEC;
            `BCM_OP_INC_FIX_DST: dec_src = `BCM_STEP_INC;
            `BCM_OP_DEC_SRC_PFX: begin
                dec_src     = `BCM_STEP_DEC;
                dec_dst     = `BCM_STEP_DEC;
                dec_pfx_src = 1'b1;
            end
            `BCM_OP_INC_SRC_PFX: begin
                dec_src     = `BCM_STEP_INC;
                dec_dst     = `BCM_STEP_INC;
                dec_pfx_src = 1'b1;
            end
            `BCM_OP_FIX_SRC_DEC: begin
                dec_dst     = `BCM_STEP_DEC;
                dec_pfx_src = 1'b1;
            end
            `BCM_OP_FIX_SRC_INC: begin
                dec_dst     = `BCM_STEP_INC;
                dec_pfx_src = 1'b1;
            end
            default: dec_hit = 1'b0;
        endcase
    end

    function [15:0] step;
        input [15:0] v;
        input [1:0]  s;
        begin
            case (s)
                `BCM_STEP_INC: step = v + `BCM_ONE16;
                `BCM_STEP_DEC: step = v - `BCM_ONE16;
                default:       step = v;
            endcase
        end
    endfunction

    // ************************************************************
    // sequencer
    // ************************************************************
    reg [2:0]  st_r;
    reg        mul_r;
    reg        sub_r;
    reg [1:0]  src_r;
    reg [1:0]  dst_r;
    reg        pfx_src_r;
    reg        pint_r;
    reg        pext_r;
    reg [7:0]  byte_a_r;
    reg [7:0]  byte_b_r;
    reg [7:0]  res_r;

    // product: b*de + de' + cy fits 24 bits
    wire [23:0] prod = byte_b_r * second_pair + {8'h00, alt_second_pair}
                       + {23'h000000, carry_flag};
    wire [24:0] sum  = {17'h00000, byte_a_r} + {1'b0, prod};
    wire [24:0] dif  = {17'h00000, byte_a_r} - {1'b0, prod};
    wire [24:0] mres = sub_r ? dif : sum;
    // the borrow of a subtract shows as the whole upper part going negative
    wire [15:0] cnt_dec = counter_pair - `BCM_ONE16;

    wire        buf_in_ready;
    wire        buf_out_valid;
    wire [25:0] buf_out_data;
    reg         buf_push;
    reg  [25:0] buf_word;

    bcm_skid #(.W(26)) u_buf (
        .clk       (core_clk),
        .rst       (sys_rst),
        .in_valid  (buf_push),
        .in_ready  (buf_in_ready),
        .in_data   (buf_word),
        .out_valid (buf_out_valid),
        .out_ready (wr_ready | ~wr_valid),
        .out_data  (buf_out_data)
    );

    always @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            wr_valid  <= 1'b0;
            wr_addr   <= 16'h0000;
            wr_data   <= 8'h00;
            wr_io_int <= 1'b0;
            wr_io_ext <= 1'b0;
        end else if (wr_ready | ~wr_valid) begin
            wr_valid  <= buf_out_valid;
            wr_addr   <= buf_out_data[25:10];
            wr_data   <= buf_out_data[9:2];
            wr_io_int <= buf_out_data[1];
            wr_io_ext <= buf_out_data[0];
        end
    end

    always @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            st_r <= `BCM_ST_IDLE;
            {mul_r, sub_r, pfx_src_r, pint_r, pext_r} <= 5'h00;
            src_r <= `BCM_STEP_NONE;
            dst_r <= `BCM_STEP_NONE;
            byte_a_r <= 8'h00;
            byte_b_r <= 8'h00;
            res_r <= 8'h00;
            op_accept <= 1'b0;
            busy <= 1'b0;
            done <= 1'b0;
            counter_pair <= 16'h0000;
            second_pair <= 16'h0000;
            alt_second_pair <= 16'h0000;
            third_pair <= 16'h0000;
            first_index <= 16'h0000;
            second_index <= 16'h0000;
            carry_flag <= 1'b0;
            overflow_flag <= 1'b0;
            rd_req <= 1'b0;
            rd_addr <= 16'h0000;
            rd_io_int <= 1'b0;
            rd_io_ext <= 1'b0;
            buf_push <= 1'b0;
            buf_word <= 26'h000_0000;
        end else begin
            op_accept <= 1'b0;
            done <= 1'b0;
            if (buf_push && buf_in_ready)
                buf_push <= 1'b0;
            case (st_r)
                `BCM_ST_IDLE: if (op_valid && dec_hit) begin
                    op_accept <= 1'b1;
                    busy <= 1'b1;
                    {mul_r, sub_r, pfx_src_r} <= {dec_mul, dec_sub, dec_pfx_src};
                    src_r <= dec_src;
                    dst_r <= dec_dst;
                    pint_r <= io_pfx_int;
                    pext_r <= io_pfx_ext;
                    counter_pair <= counter_pair_in;
                    second_pair <= second_pair_in;
                    alt_second_pair <= alt_second_pair_in;
                    third_pair <= third_pair_in;
                    first_index <= first_index_in;
                    second_index <= second_index_in;
                    carry_flag <= carry_flag_in;
                    st_r <= `BCM_ST_RD_A;
                end
                `BCM_ST_RD_A: begin
                    rd_req <= 1'b1;
                    rd_addr <= mul_r ? first_index : third_pair;
                    rd_io_int <= ~mul_r & pfx_src_r & pint_r;
                    rd_io_ext <= ~mul_r & pfx_src_r & pext_r;
                    if (rd_req && rd_ack) begin
                        rd_req <= 1'b0;
                        byte_a_r <= rd_data;
                        st_r <= mul_r ? `BCM_ST_RD_B : `BCM_ST_WR;
                    end
                end
                `BCM_ST_RD_B: begin
                    rd_req <= 1'b1;
                    rd_addr <= second_index;
                    rd_io_int <= 1'b0;
                    rd_io_ext <= 1'b0;
                    if (rd_req && rd_ack) begin
                        rd_req <= 1'b0;
                        byte_b_r <= rd_data;
                        st_r <= `BCM_ST_CALC;
                    end
                end
                `BCM_ST_CALC: begin
                    res_r <= mres[7:0];
                    alt_second_pair <= mres[23:8];
                    carry_flag <= mres[24];
                    st_r <= `BCM_ST_WR;
                end
                `BCM_ST_WR: if (!buf_push || buf_in_ready) begin
                    // waits here while the buffer is full: receiver stall
                    buf_push <= 1'b1;
                    if (mul_r) begin
                        buf_word <= {third_pair, res_r, 2'b00};
                        third_pair <= third_pair + `BCM_ONE16;
                        first_index <= first_index + `BCM_ONE16;
                        second_index <= second_index + `BCM_ONE16;
                    end else begin
                        buf_word <= {second_pair, byte_a_r,
                                     ~pfx_src_r & pint_r, ~pfx_src_r & pext_r};
                        third_pair <= step(third_pair, src_r);
                        second_pair <= step(second_pair, dst_r);
                    end
                    counter_pair <= cnt_dec;
                    overflow_flag <= (cnt_dec != `BCM_ZERO16);
                    st_r <= (cnt_dec == `BCM_ZERO16) ? `BCM_ST_DONE : `BCM_ST_RD_A;
                end
                `BCM_ST_DONE: if (!buf_push && !buf_out_valid && !wr_valid) begin
                    busy <= 1'b0;
                    done <= 1'b1;
                    st_r <= `BCM_ST_IDLE;
                end
                default: st_r <= `BCM_ST_IDLE;
            endcase
        end
    end
endmodule // bcm_exec
`default_nettype wire

// >>> sim/bcm_exec_monitor.sv
`timescale 1ns/10ps
`default_nettype none
`include "bcm_map.vh"
// ************************************************************
// port checker
// ************************************************************
module bcm_exec_monitor (
    input wire logic        core_clk,
    input wire logic        sys_rst,
    input wire logic [7:0]  op_code,
    input wire logic        op_accept,
    input wire logic        busy,
    input wire logic        done,
    input wire logic [15:0] second_pair,
    input wire logic [15:0] third_pair,
    input wire logic        rd_req,
    input wire logic        rd_ack,
    input wire logic [15:0] rd_addr,
    input wire logic        rd_io_int,
    input wire logic        rd_io_ext,
    input wire logic        wr_valid,
    input wire logic        wr_ready,
    input wire logic [15:0] wr_addr,
    input wire logic [7:0]  wr_data,
    input wire logic        wr_io_int,
    input wire logic        wr_io_ext
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (sys_rst);
    logic [7:0] code_r;
    always @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) code_r <= 8'h00;
        else if (op_accept) code_r <= op_code;
    end
    wire mul = code_r == `BCM_OP_MUL_ADD || code_r == `BCM_OP_MUL_SUB;
    wire fdst = code_r == `BCM_OP_DEC_FIX_DST || code_r == `BCM_OP_INC_FIX_DST;
    wire fsrc = code_r == `BCM_OP_FIX_SRC_DEC || code_r == `BCM_OP_FIX_SRC_INC;
    wire spfx = fsrc || code_r == `BCM_OP_DEC_SRC_PFX || code_r == `BCM_OP_INC_SRC_PFX;
    chk_accept_pulse: assert property (op_accept |=> !op_accept)
        else $error("accept longer than one cycle");
    chk_accept_idle: assert property (op_accept |-> busy && !$past(busy))
        else $error("accept while busy");
    chk_done_ends: assert property (done |=> !done && !busy)
        else $error("done not a closing pulse");
    chk_rd_hold: assert property (rd_req && !rd_ack |=> rd_req && $stable(rd_addr))
        else $error("read request dropped early");
    chk_wr_hold: assert property (
        wr_valid && !wr_ready |=> wr_valid && $stable({wr_addr, wr_data}))
        else $error("write word changed before ready");
    chk_dest_fixed: assert property (
        busy && !op_accept && fdst ##1 busy |-> $stable(second_pair))
        else $error("fixed destination moved");
    chk_src_fixed: assert property (
        busy && !op_accept && fsrc ##1 busy |-> $stable(third_pair))
        else $error("fixed source moved");
    chk_mul_rd_mem: assert property (
        rd_req && mul |-> !rd_io_int && !rd_io_ext)
        else $error("multiply read in io space");
    chk_src_wr_mem: assert property (
        wr_valid && spfx |-> !wr_io_int && !wr_io_ext)
        else $error("source-prefixed copy wrote io");
    cov_sub: cover property (op_accept && op_code == `BCM_OP_MUL_SUB);
    cov_stall: cover property (wr_valid && !wr_ready ##1 wr_valid && !wr_ready);
    cov_done: cover property (done);
endmodule // bcm_exec_monitor
bind bcm_exec bcm_exec_monitor i_mon (.core_clk, .sys_rst, .op_code, .op_accept, .busy, .done,
    .second_pair, .third_pair, .rd_req, .rd_ack, .rd_addr, .rd_io_int, .rd_io_ext,
    .wr_valid, .wr_ready, .wr_addr, .wr_data, .wr_io_int, .wr_io_ext);
`default_nettype wire

// >>> sim/bcm_mem_model.sv
`timescale 1ns/10ps
`default_nettype none
// ************************************************************
// memory and io bus model
// ************************************************************
module bcm_mem_model (
    input  wire logic        core_clk,
    input  wire logic        sys_rst,
    input  wire logic        slow,
    input  wire logic        rd_req,
    input  wire logic [15:0] rd_addr,
    input  wire logic        rd_io_int,
    input  wire logic        rd_io_ext,
    output var  logic        rd_ack,
    output wire logic [7:0]  rd_data,
    output var  logic        wr_ready
);
    // contents are a function of address and space, so writes need no storage
    wire [7:0] val = rd_addr[7:0] ^ rd_addr[15:8] ^ {rd_io_int, rd_io_ext, 6'h00};
    // inverse off the ack cycle so stale data never passes
    assign rd_data = rd_ack ? val : ~val;
    always @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            rd_ack <= 1'b0;
            wr_ready <= 1'b0;
        end else begin
            rd_ack <= rd_req && !rd_ack && (!slow || $urandom_range(2) == 0);
            wr_ready <= !slow || $urandom_range(3) == 0;
        end
    end
endmodule // bcm_mem_model
`default_nettype wire

// >>> sim/testbench.sv
`timescale 1ns/10ps
`default_nettype none
`include "bcm_map.vh"
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin n_errors++; \
    $display("BAD t=%0t got=%h exp=%h", $time, a, b); end end
module testbench;
    logic        core_clk, sys_rst, op_valid, io_pfx_int, io_pfx_ext, carry_flag_in, slow;
    logic [7:0]  op_prefix, op_code, rd_data, wr_data;
    logic [15:0] counter_pair_in, second_pair_in, alt_second_pair_in, third_pair_in;
    logic [15:0] first_index_in, second_index_in, rd_addr, wr_addr;
    logic [15:0] counter_pair, second_pair, alt_second_pair, third_pair, first_index;
    logic [15:0] second_index;
    logic        op_accept, busy, done, carry_flag, overflow_flag, rd_req, rd_io_int;
    logic        rd_io_ext, rd_ack, wr_valid, wr_ready, wr_io_int, wr_io_ext;
    int          n_errors = 0, checked = 0, i, p;
    logic [25:0] exp_q[$];
    logic [7:0]  codes[10] = '{8'hB8, 8'hB0, 8'h98, 8'h90, 8'hF8, 8'hD0, 8'h18, 8'h10,
                               8'hC0, 8'hC8};
    bcm_exec i_dut (.core_clk, .sys_rst, .op_valid, .op_prefix, .op_code, .io_pfx_int,
        .io_pfx_ext, .counter_pair_in, .second_pair_in, .alt_second_pair_in, .third_pair_in,
        .first_index_in, .second_index_in, .carry_flag_in, .op_accept, .busy, .done,
        .counter_pair, .second_pair, .alt_second_pair, .third_pair, .first_index,
        .second_index, .carry_flag, .overflow_flag, .rd_req, .rd_addr, .rd_io_int,
        .rd_io_ext, .rd_ack, .rd_data, .wr_valid, .wr_ready, .wr_addr, .wr_data,
        .wr_io_int, .wr_io_ext);
    bcm_mem_model i_mem (.core_clk, .sys_rst, .slow, .rd_req, .rd_addr, .rd_io_int,
        .rd_io_ext, .rd_ack, .rd_data, .wr_ready);
    function automatic logic [7:0] mem(input logic [15:0] a, input logic [1:0] io);
        return a[7:0] ^ a[15:8] ^ {io, 6'h00};
    endfunction
    task automatic report_and_stop;
        $display("errors=%0d checks=%0d", n_errors, checked);
        if (n_errors == 0 && checked > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    task automatic run_op(input logic [7:0] code, input int cnt);
        logic [15:0] de, dep, hl, ix, iy;
        logic [24:0] r, t;
        logic [1:0]  io, sio, dio;
        logic        cy, mul, dpf;
        int          ss, ds, k;
        de = $urandom;
        dep = $urandom;
        hl = $urandom;
        ix = $urandom;
        iy = $urandom;
        cy = $urandom;
        io = $urandom;
        @(posedge core_clk);
        op_valid <= 1'b1;
        op_prefix <= `BCM_PREFIX;
        op_code <= code;
        {io_pfx_int, io_pfx_ext} <= io;
        counter_pair_in <= cnt[15:0];
        {second_pair_in, alt_second_pair_in, third_pair_in} <= {de, dep, hl};
        {first_index_in, second_index_in, carry_flag_in} <= {ix, iy, cy};
        mul = code == `BCM_OP_MUL_ADD || code == `BCM_OP_MUL_SUB;
        ss = (code == 8'h18 || code == 8'h10) ? 0 : (code[3] ? -1 : 1);
        ds = (code == 8'h98 || code == 8'h90) ? 0 : (code[3] ? -1 : 1);
        dpf = code == 8'hB8 || code == 8'hB0 || code == 8'h98 || code == 8'h90;
        sio = dpf ? 2'b00 : io;
        dio = dpf ? io : 2'b00;
        for (k = 0; k < cnt; k++) begin
            if (mul) begin
                t = 25'(mem(iy, 2'b00)) * 25'(de) + 25'(dep) + 25'(cy);
                r = code == `BCM_OP_MUL_ADD ? 25'(mem(ix, 2'b00)) + t : 25'(mem(ix, 2'b00)) - t;
                exp_q.push_back({2'b00, hl, r[7:0]});
                {cy, dep} = {r[24], r[23:8]};
                {ix, iy, hl} = {ix + 16'h0001, iy + 16'h0001, hl + 16'h0001};
            end else begin
                exp_q.push_back({dio, de, mem(hl, sio)});
                hl = hl + 16'(ss);
                de = de + 16'(ds);
            end
        end
        for (k = 0; k < 50 && op_accept !== 1'b1; k++) @(posedge core_clk);
        op_valid <= 1'b0;
        for (k = 0; k < 600 && done !== 1'b1; k++) @(posedge core_clk);
        `CHK(done, 1'b1)
        `CHK({counter_pair, overflow_flag}, 17'h0_0000)
        `CHK({third_pair, second_pair}, {hl, de})
        `CHK({first_index, second_index}, {ix, iy})
        `CHK({alt_second_pair, carry_flag}, {dep, cy})
        for (k = 0; k < 300 && exp_q.size() != 0; k++) @(posedge core_clk);
        `CHK(exp_q.size(), 0)
    endtask
    always @(posedge core_clk) begin : wr_watch
        logic [25:0] e;
        if (wr_valid === 1'b1 && wr_ready === 1'b1) begin
            e = exp_q.pop_front();
            `CHK({wr_io_int, wr_io_ext, wr_addr, wr_data}, e)
        end
    end
    initial begin
        core_clk = 1'b0;
        forever #20 core_clk = ~core_clk;
    end
    initial begin
        #(40 * 20000);
        n_errors++;
        report_and_stop;
    end
    initial begin
        void'($urandom(32'hc6bb));
        {sys_rst, slow, op_valid, io_pfx_int, io_pfx_ext, carry_flag_in} = 6'h20;
        {op_prefix, op_code} = 16'h0000;
        {counter_pair_in, second_pair_in, alt_second_pair_in} = 48'h0;
        {third_pair_in, first_index_in, second_index_in} = 48'h0;
        repeat (6) @(posedge core_clk);
        sys_rst <= 1'b0;
        @(posedge core_clk);
        op_valid <= 1'b1;
        op_prefix <= `BCM_PREFIX;
        repeat (6) begin
            @(posedge core_clk);
            `CHK({op_accept, busy}, 2'b00)
        end
        op_valid <= 1'b0;
        for (p = 0; p < 2; p++) begin
            slow <= p[0];
            for (i = 0; i < 10; i++) run_op(codes[i], 1 + (i + p) % 4);
        end
        // a zero count wraps and runs on; cut it short with a reset in mid-run
        @(posedge core_clk);
        op_valid <= 1'b1;
        op_code <= `BCM_OP_LEG_INC;
        {io_pfx_int, io_pfx_ext} <= 2'b00;
        counter_pair_in <= 16'h0000;
        for (i = 0; i < 3; i++)
            exp_q.push_back({2'b00, second_pair_in + 16'(i), mem(third_pair_in + 16'(i), 2'b00)});
        for (i = 0; i < 300 && counter_pair !== 16'hFFFE; i++) @(posedge core_clk);
        op_valid <= 1'b0;
        `CHK({busy, done, counter_pair}, {2'b10, 16'hFFFE})
        sys_rst <= 1'b1;
        @(posedge core_clk);
        `CHK({op_accept, busy, rd_req, wr_valid, counter_pair}, 20'h0_0000)
        exp_q.delete();
        sys_rst <= 1'b0;
        run_op(`BCM_OP_LEG_DEC, 2);
        report_and_stop;
    end
endmodule // testbench
`default_nettype wire
